// ### design/isto_exec.sv
// Purpose: executes indirect store, option load, software reset, irq return, no-op
// Assumes: one instruction offered per cycle with i_valid; stack lives outside
// Notes:   o_ready falls during the second cycle of an irq return
//          the stack itself lives in the core; this block only asks for a pop
//          a software reset is only a request pulse; the core answers with i_rst
//          flags are never written, so status bits survive every op here
//          the offset form has its own adder and never writes back
//          unknown words are left to the rest of the core and do nothing here
//
// Contract
// - indirect port writes go to selected pointer address
// - update field picks pre/post increment/decrement
// - pointers are 16 bits and wrap
// - pointer updates never touch status flags
// - option load copies working register, flags untouched
// - software reset resets device, clears reset flag
// - irq return pops stack, loads pc, sets enable
`timescale 1ns/10ps
`default_nettype none
module isto_exec #(
    parameter int PTR_W = isto_pkg::ISTO_PTR_W
) (
    input  wire logic                             i_mclk,
    input  wire logic                             i_rst,
    input  wire logic                             i_valid,
    input  wire logic [isto_pkg::ISTO_INSN_W-1:0] i_insn,
    input  wire logic [isto_pkg::ISTO_DATA_W-1:0] i_wreg,
    input  wire logic [isto_pkg::ISTO_PC_W-1:0]   i_stack_top_entry,
    output logic                                  o_ready,
    output logic                                  o_mem_we,
    output logic      [PTR_W-1:0]                 o_mem_addr,
    output logic      [isto_pkg::ISTO_DATA_W-1:0] o_mem_data,
    output logic      [PTR_W-1:0]                 o_ptr0,
    output logic      [PTR_W-1:0]                 o_ptr1,
    output logic      [isto_pkg::ISTO_DATA_W-1:0] o_option,
    output logic                                  o_flags_we,
    output logic                                  o_pc_inc,
    output logic                                  o_stack_pop,
    output logic                                  o_pc_load,
    output logic      [isto_pkg::ISTO_PC_W-1:0]   o_pc_value,
    output logic                                  o_global_irq_enable_set,
    output logic                                  o_soft_reset,
    output logic                                  o_reset_instr_flag_clr
);
    import isto_pkg::*;

    // ****************************************
    // parameter check
    // ****************************************
    // the wrap and offset adders are sized for the full 16-bit pointer only
    if (PTR_W != ISTO_PTR_W) begin : g_bad_ptr_w
        $error("pointer width must be 16");
    end

    // the second phase only stretches the irq return to two cycles
    typedef enum logic [0:0] {ISTO_S_RUN, ISTO_S_RET2} isto_state_t;

    // every register of the block lives in this one struct
    typedef struct packed {
        isto_state_t                ph;
        logic [1:0][PTR_W-1:0]      ptr;
        logic [ISTO_DATA_W-1:0]     option;
        logic                       mem_we;
        logic [PTR_W-1:0]           mem_addr;
        logic [ISTO_DATA_W-1:0]     mem_data;
        logic                       pc_inc;
        logic                       pop;
        logic                       pc_load;
        logic [ISTO_PC_W-1:0]       pc_value;
        logic                       gie_set;
        logic                       sw_reset;
    } isto_st_t;

    // registered state and the value it takes at the next edge
    isto_st_t st;
    isto_st_t next_st;

    // decoded fields travel in one bundle so the decoder stays a plain table
    isto_dec_if dec_bus ();

    // ****************************************
    // decode
    // ****************************************
    isto_decode u_dec (
        .i_insn (i_insn),
        .dec    (dec_bus)
    );

    // step a pointer by one, wrapping modulo the full 16-bit range
    function automatic logic [PTR_W-1:0] isto_step(input logic [PTR_W-1:0] p,
                                                   input logic dn);
        isto_step = dn ? p - ISTO_PTR_ONE : p + ISTO_PTR_ONE;
    endfunction

    // pre forms move the pointer before the write, post forms after it
    function automatic logic isto_is_pre(input logic [1:0] upd);
        isto_is_pre = (upd == ISTO_UPD_PREINC) || (upd == ISTO_UPD_PREDEC);
    endfunction

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        logic [PTR_W-1:0] cur;
        logic [PTR_W-1:0] stepped;
        logic             dn;
        // the chosen pointer feeds every store form, its one-step neighbour only the update form
        cur     = st.ptr[dec_bus.sel];
        dn      = dec_bus.upd[0];
        stepped = isto_step(cur, dn);
        // hold everything by default; the strobes fall back to zero each cycle
        next_st          = st;
        next_st.mem_we   = 1'b0;
        next_st.pc_inc   = 1'b0;
        next_st.pop      = 1'b0;
        next_st.pc_load  = 1'b0;
        next_st.gie_set  = 1'b0;
        next_st.sw_reset = 1'b0;
        unique case (st.ph)
            // ready stands in this phase, so an offered op is taken
            ISTO_S_RUN: begin
                if (i_valid) begin
                    // the decoder never yields the spare code, so no default
                    unique case (dec_bus.kind)
                        ISTO_K_STORE: begin
                            // pre forms write the stepped address, post forms the old one
                            next_st.mem_we   = 1'b1;
                            next_st.mem_data = i_wreg;
                            next_st.mem_addr = isto_is_pre(dec_bus.upd) ? stepped : cur;
                            next_st.ptr[dec_bus.sel] = stepped;
                            next_st.pc_inc   = 1'b1;
                        end
                        ISTO_K_REL: begin
                            // the sum only forms the address; the pointer keeps its value
                            next_st.mem_we   = 1'b1;
                            next_st.mem_data = i_wreg;
                            next_st.mem_addr = cur + dec_bus.ofs;
                            next_st.pc_inc   = 1'b1;
                        end
                        ISTO_K_OPTION: begin
                            // the whole working register goes across, no flag strobe
                            next_st.option   = i_wreg;
                            next_st.pc_inc   = 1'b1;
                        end
                        ISTO_K_RESET: begin
                            // no pc advance: the core restarts from its reset vector
                            next_st.sw_reset = 1'b1;
                        end
                        ISTO_K_RETFI: begin
                            // pop and load pulse in the second cycle, the same cycle as the stall
                            next_st.pop      = 1'b1;
                            next_st.pc_load  = 1'b1;
                            next_st.pc_value = i_stack_top_entry;
                            next_st.gie_set  = 1'b1;
                            next_st.ph       = ISTO_S_RET2;
                        end
                        ISTO_K_NOP: begin
                            // only the pc moves
                            next_st.pc_inc   = 1'b1;
                        end
                        ISTO_K_OTHER: begin
                            // stay silent so this block and the core never both act
                            next_st.pc_inc   = 1'b0; // left to the rest of the core
                        end
                    endcase
                end
            end
            // stall cycle: ready is low and anything offered now is dropped
            ISTO_S_RET2: begin
                next_st.ph = ISTO_S_RUN;
            end
        endcase
    end

    // ****************************************
    // state register
    // ****************************************
    // synchronous reset puts every field back to its start value
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            st.ph       <= ISTO_S_RUN;
            st.ptr      <= '0;
            st.option   <= ISTO_OPTION_RST;
            st.mem_we   <= 1'b0;
            st.mem_addr <= ISTO_PTR_RST;
            st.mem_data <= '0;
            st.pc_inc   <= 1'b0;
            st.pop      <= 1'b0;
            st.pc_load  <= 1'b0;
            st.pc_value <= '0;
            st.gie_set  <= 1'b0;
            st.sw_reset <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    // none of these ops writes flags, so the flag strobe is held low
    assign o_flags_we              = 1'b0;
    // combinational so the stall shows in the very cycle it begins
    assign o_ready                 = (st.ph == ISTO_S_RUN);
    assign o_mem_we                = st.mem_we;
    assign o_mem_addr              = st.mem_addr;
    assign o_mem_data              = st.mem_data;
    // pointers and option are plain register copies
    assign o_ptr0                  = st.ptr[0];
    assign o_ptr1                  = st.ptr[1];
    assign o_option                = st.option;
    // pc and stack strobes are one-cycle pulses for the core's sequencer
    assign o_pc_inc                = st.pc_inc;
    assign o_stack_pop             = st.pop;
    assign o_pc_load               = st.pc_load;
    assign o_pc_value              = st.pc_value;
    assign o_global_irq_enable_set = st.gie_set;
    // the core feeds o_soft_reset back into its reset tree
    assign o_soft_reset            = st.sw_reset;
    assign o_reset_instr_flag_clr  = st.sw_reset;
endmodule
`default_nettype wire

// ### design/isto_pkg.sv
// Purpose: shared constants and types for the indirect store and misc ops executor
// Assumes: 14-bit instruction words, 8-bit data, 16-bit pointers
// Notes:   opcode patterns follow the usual enhanced mid-range core encoding
package isto_pkg;
    localparam int          ISTO_INSN_W     = 14;
    localparam int          ISTO_DATA_W     = 8;
    localparam int          ISTO_PTR_W      = 16;
    localparam int          ISTO_PC_W       = 15;
    localparam int          ISTO_OFS_W      = 6;
    // opcode patterns
    localparam logic [13:0] ISTO_OP_NOP     = 14'h0000;
    localparam logic [13:0] ISTO_OP_RESET   = 14'h0001;
    localparam logic [13:0] ISTO_OP_RETFI   = 14'h0009;
    localparam logic [13:0] ISTO_OP_OPTION  = 14'h0062;
    localparam logic [10:0] ISTO_OP_ST_MODE = 11'h003;  // insn[13:3] of the update form
    localparam logic [6:0]  ISTO_OP_ST_REL  = 7'h7F;    // insn[13:7] of the offset form
    // field positions
    localparam int          ISTO_SEL_MODE   = 2;        // pointer select, update form
    localparam int          ISTO_SEL_REL    = 6;        // pointer select, offset form
    // update field encodings
    localparam logic [1:0]  ISTO_UPD_PREINC = 2'h0;
    localparam logic [1:0]  ISTO_UPD_PREDEC = 2'h1;
    localparam logic [1:0]  ISTO_UPD_POSINC = 2'h2;
    localparam logic [1:0]  ISTO_UPD_POSDEC = 2'h3;
    // reset values, the pointer step and the irq return length
    localparam logic [7:0]  ISTO_OPTION_RST = 8'hFF;
    localparam logic [15:0] ISTO_PTR_RST    = 16'h0000;
    localparam logic [15:0] ISTO_PTR_ONE    = 16'h0001;
    localparam int          ISTO_RETFI_CYC  = 2;

    typedef enum logic [2:0] {
        ISTO_K_NOP,
        ISTO_K_STORE,
        ISTO_K_REL,
        ISTO_K_OPTION,
        ISTO_K_RESET,
        ISTO_K_RETFI,
        ISTO_K_OTHER
    } isto_kind_t;
endpackage

// ### design/isto_dec_if.sv
// Purpose: carries decoded instruction fields from decoder to executor
// Assumes: one decoded instruction per clock
// Notes:   purely combinational bundle
`timescale 1ns/10ps
`default_nettype none
interface isto_dec_if;
    import isto_pkg::*;
    isto_kind_t       kind;
    logic             sel;
    logic [1:0]       upd;
    logic [15:0]      ofs;
    modport dec (output kind, sel, upd, ofs);
    modport exe (input  kind, sel, upd, ofs);
endinterface
`default_nettype wire

// ### design/isto_decode.sv
// Purpose: classifies an instruction word and extracts store fields
// Assumes: word is valid whenever the caller presents it
// Notes:   offset is sign-extended to the pointer width here
`timescale 1ns/10ps
`default_nettype none
module isto_decode (
    input  wire logic [isto_pkg::ISTO_INSN_W-1:0] i_insn,
    isto_dec_if.dec                               dec
);
    import isto_pkg::*;

    // ****************************************
    // classification
    // ****************************************
    always_comb begin
        dec.kind = ISTO_K_OTHER;
        dec.sel  = 1'b0;
        dec.upd  = i_insn[1:0];
        dec.ofs  = {{(ISTO_PTR_W-ISTO_OFS_W){i_insn[ISTO_OFS_W-1]}}, i_insn[ISTO_OFS_W-1:0]};
        if (i_insn == ISTO_OP_NOP) begin
            dec.kind = ISTO_K_NOP;
        end else if (i_insn == ISTO_OP_RESET) begin
            dec.kind = ISTO_K_RESET;
        end else if (i_insn == ISTO_OP_RETFI) begin
            dec.kind = ISTO_K_RETFI;
        end else if (i_insn == ISTO_OP_OPTION) begin
            dec.kind = ISTO_K_OPTION;
        end else if (i_insn[13:3] == ISTO_OP_ST_MODE) begin
            dec.kind = ISTO_K_STORE;
            dec.sel  = i_insn[ISTO_SEL_MODE];
        end else if (i_insn[13:7] == ISTO_OP_ST_REL) begin
            dec.kind = ISTO_K_REL;
            dec.sel  = i_insn[ISTO_SEL_REL];
        end
    end
endmodule
`default_nettype wire

// ### bench/isto_chk.sv
// Purpose: port assertions for the indirect store and misc ops executor
// Assumes: one clock, synchronous active-high reset
// Notes:   attached by the bind below the module
`timescale 1ns/10ps
`default_nettype none
module isto_chk (
    input wire logic        i_mclk,
    input wire logic        i_rst,
    input wire logic        i_valid,
    input wire logic [13:0] i_insn,
    input wire logic [7:0]  i_wreg,
    input wire logic [14:0] i_stack_top_entry,
    input wire logic        o_ready,
    input wire logic        o_mem_we,
    input wire logic [15:0] o_mem_addr,
    input wire logic [15:0] o_ptr0,
    input wire logic [15:0] o_ptr1,
    input wire logic [7:0]  o_option,
    input wire logic        o_flags_we,
    input wire logic        o_pc_inc,
    input wire logic        o_stack_pop,
    input wire logic        o_pc_load,
    input wire logic [14:0] o_pc_value,
    input wire logic        o_global_irq_enable_set,
    input wire logic        o_soft_reset,
    input wire logic        o_reset_instr_flag_clr
);
    import isto_pkg::*;
    // ****
    // taken requests and the offset-form target
    // ****
    wire        take   = i_valid && o_ready;
    wire        st     = take && i_insn[13:3] == ISTO_OP_ST_MODE;
    wire [15:0] rel_ea = (i_insn[6] ? o_ptr1 : o_ptr0) + {{10{i_insn[5]}}, i_insn[5:0]};
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    // irq return is two steps: pulses with ready low, then ready back
    sequence ret_pulses;
        o_stack_pop && o_pc_load && o_global_irq_enable_set && !o_ready
        && o_pc_value == $past(i_stack_top_entry);
    endsequence
    sequence ret_done;
        ret_pulses ##1 (o_ready && !o_stack_pop);
    endsequence
    pre_inc_a: assert property (
        st && i_insn[2:0] == 3'h0 |=> o_mem_we && o_mem_addr == $past(o_ptr0) + 16'h1
        && o_ptr0 == o_mem_addr) else $error("preinc store wrong");
    post_dec_a: assert property (
        st && i_insn[2:0] == 3'h7 |=> o_mem_addr == $past(o_ptr1)
        && o_ptr1 == $past(o_ptr1) - 16'h1) else $error("postdec store wrong");
    rel_store_a: assert property (
        take && i_insn[13:7] == ISTO_OP_ST_REL |=> o_mem_we && o_mem_addr == $past(rel_ea)
        && $stable(o_ptr0) && $stable(o_ptr1)) else $error("offset store wrong");
    no_flags_a: assert property (!o_flags_we) else $error("flags written");
    option_load_a: assert property (
        take && i_insn == ISTO_OP_OPTION |=> o_option == $past(i_wreg) && o_pc_inc)
        else $error("option load wrong");
    soft_reset_a: assert property (
        take && i_insn == ISTO_OP_RESET |=> o_soft_reset && o_reset_instr_flag_clr
        ##1 !o_soft_reset) else $error("soft reset pulse wrong");
    irq_return_a: assert property (
        take && i_insn == ISTO_OP_RETFI |=> ret_done) else $error("irq return wrong");
    refused_req_a: assert property (
        i_valid && !o_ready |=> !o_pc_inc && !o_mem_we) else $error("refused op ran");
    nop_idle_a: assert property (
        take && i_insn == ISTO_OP_NOP |=> o_pc_inc && !o_mem_we && $stable(o_ptr0)
        && $stable(o_ptr1) && $stable(o_option)) else $error("nop changed state");
endmodule
bind isto_exec isto_chk u_chk (.i_mclk, .i_rst, .i_valid, .i_insn, .i_wreg,
    .i_stack_top_entry, .o_ready, .o_mem_we, .o_mem_addr, .o_ptr0, .o_ptr1, .o_option,
    .o_flags_we, .o_pc_inc, .o_stack_pop, .o_pc_load, .o_pc_value,
    .o_global_irq_enable_set, .o_soft_reset, .o_reset_instr_flag_clr);
`default_nettype wire

// ### bench/tb_top.sv
// Purpose: self-checking bench for the indirect store and misc ops executor
// Assumes: answers registered at the taking edge, read on the next falling edge
// Notes:   inputs change on the falling edge only
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import isto_pkg::*;
    logic        i_mclk = 1'b0;
    logic        i_rst = 1'b1;
    logic        i_valid = 1'b0;
    logic [13:0] i_insn = 14'h0000;
    logic [7:0]  i_wreg = 8'h00;
    logic [14:0] i_stack_top_entry = 15'h0000;
    logic        o_ready, o_mem_we, o_flags_we, o_pc_inc, o_stack_pop, o_pc_load;
    logic        o_global_irq_enable_set, o_soft_reset, o_reset_instr_flag_clr;
    logic [15:0] o_mem_addr, o_ptr0, o_ptr1;
    logic [7:0]  o_mem_data, o_option;
    logic [14:0] o_pc_value;
    logic [15:0] ptr [2] = '{16'h0000, 16'h0000};
    int          errors = 0;
    int          total_checks = 0;
    // 200 MHz clock
    always #2.5 i_mclk = ~i_mclk;
    isto_exec uut (.i_mclk, .i_rst, .i_valid, .i_insn, .i_wreg, .i_stack_top_entry,
        .o_ready, .o_mem_we, .o_mem_addr, .o_mem_data, .o_ptr0, .o_ptr1, .o_option,
        .o_flags_we, .o_pc_inc, .o_stack_pop, .o_pc_load, .o_pc_value,
        .o_global_irq_enable_set, .o_soft_reset, .o_reset_instr_flag_clr);
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // one gap cycle per op, so valid is never set twice in one step
    task automatic op(input logic [13:0] insn, input logic [7:0] w);
        @(negedge i_mclk);
        i_valid = 1'b1;
        i_insn = insn;
        i_wreg = w;
        @(negedge i_mclk);
        i_valid = 1'b0;
    endtask
    task automatic t_nop;
        op(ISTO_OP_NOP, 8'h5A);
        chk(o_pc_inc, 1'b1);
        chk(o_mem_we, 1'b0);
        chk(o_ptr0 | o_ptr1, ISTO_PTR_RST);
        chk(o_option, ISTO_OPTION_RST);
        op(14'h3000, 8'h5A);
        chk(o_pc_inc, 1'b0);
        $display("t_nop done");
    endtask
    // first step of each pointer goes down from zero to force a wrap
    task automatic t_store;
        logic [1:0]  m;
        logic        s;
        logic [15:0] nxt;
        for (int i = 0; i < 8; i++) begin
            s = i[2];
            m = i[1:0] ^ 2'h1;
            nxt = m[0] ? ptr[s] - 16'h1 : ptr[s] + 16'h1;
            op({ISTO_OP_ST_MODE, s, m}, 8'hA0 + 8'(i));
            chk(o_mem_addr, m[1] ? ptr[s] : nxt);
            ptr[s] = nxt;
            chk(o_mem_we, 1'b1);
            chk(o_mem_data, 8'hA0 + 8'(i));
            chk(o_ptr0, ptr[0]);
            chk(o_ptr1, ptr[1]);
            chk(o_flags_we, 1'b0);
        end
        $display("t_store done");
    endtask
    task automatic t_rel;
        logic [5:0] k;
        op({ISTO_OP_ST_MODE, 1'b1, ISTO_UPD_PREINC}, 8'h11);
        ptr[1] = ptr[1] + 16'h1;
        for (int i = 0; i < 2; i++) begin
            k = i ? 6'h1F : 6'h20;
            op({ISTO_OP_ST_REL, i[0], k}, 8'h3C);
            chk(o_mem_addr, ptr[i] + {{10{k[5]}}, k});
            chk(o_ptr0, ptr[0]);
            chk(o_ptr1, ptr[1]);
        end
        $display("t_rel done");
    endtask
    task automatic t_option;
        op(ISTO_OP_OPTION, 8'h4F);
        chk(o_option, 8'h4F);
        chk(o_pc_inc, 1'b1);
        chk(o_flags_we, 1'b0);
        $display("t_option done");
    endtask
    // an option load offered during the stall cycle must be ignored
    task automatic t_ret;
        @(negedge i_mclk);
        i_valid = 1'b1;
        i_insn = ISTO_OP_RETFI;
        i_stack_top_entry = 15'h2A5C;
        @(negedge i_mclk);
        chk(o_stack_pop & o_pc_load & o_global_irq_enable_set, 1'b1);
        chk(o_pc_value, 15'h2A5C);
        chk(o_ready, 1'b0);
        i_insn = ISTO_OP_OPTION;
        i_wreg = 8'h00;
        @(negedge i_mclk);
        i_valid = 1'b0;
        chk(o_ready, 1'b1);
        chk(o_pc_inc | o_stack_pop, 1'b0);
        chk(o_option, 8'h4F);
        $display("t_ret done");
    endtask
    // the core answers the pulse with a reset of this block
    task automatic t_reset;
        op(ISTO_OP_RESET, 8'h00);
        chk(o_soft_reset, 1'b1);
        chk(o_reset_instr_flag_clr, 1'b1);
        chk(o_pc_inc, 1'b0);
        @(negedge i_mclk);
        chk(o_soft_reset, 1'b0);
        @(negedge i_mclk);
        i_rst = 1'b1;
        @(negedge i_mclk);
        i_rst = 1'b0;
        ptr[0] = ISTO_PTR_RST;
        ptr[1] = ISTO_PTR_RST;
        chk(o_option, ISTO_OPTION_RST);
        chk(o_ptr1, ptr[1]);
        chk(o_mem_addr, ISTO_PTR_RST);
        chk(o_ready, 1'b1);
        $display("t_reset done");
    endtask
    initial begin
        repeat (2) @(negedge i_mclk);
        i_rst = 1'b0;
        t_nop;
        t_store;
        t_rel;
        t_option;
        t_ret;
        t_reset;
        t_nop;
        give_verdict;
    end
    // hang guard
    initial begin
        repeat (5000) @(posedge i_mclk);
        errors++;
        give_verdict;
    end
endmodule
`default_nettype wire
